/* logic/spi_link.sv */
// Serial shifter on the host's clock: collects 16-bit frames, shifts out the reply.
// Assumes the serial clock is low when select falls and idles outside frames.
`timescale 1ns/10ps
`default_nettype none
module spi_link (
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic serial_select_n_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  spi_frame_if.link frm
);
  logic sel_rst;
  logic last_bit;
  logic [4:0] bit_cnt_r;
  logic [3:0] out_idx_r;
  logic [14:0] shift_r;
  logic [15:0] frame_r;
  logic tgl_r;

  // Select high clears the shifter, so a short frame leaves no trace
  assign sel_rst = serial_select_n_i | rst_i;
  assign last_bit = (bit_cnt_r == 5'h0f);

  always_ff @(negedge link_clk_i or posedge sel_rst) begin
    if (sel_rst) begin
      bit_cnt_r <= 5'h00;
      shift_r <= 15'h0000;
    end else begin
      shift_r <= {shift_r[13:0], serial_in_i};
      if (bit_cnt_r != 5'h10) begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end
  end

  // Only a full 16th bit hands a frame over; word stays until the next one
  always_ff @(negedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      frame_r <= 16'h0000;
      tgl_r <= 1'b0;
    end else if (last_bit && !serial_select_n_i) begin
      frame_r <= {shift_r, serial_in_i};
      tgl_r <= ~tgl_r;
    end
  end

  // Output moves on the rising edge after each sampling edge
  always_ff @(posedge link_clk_i or posedge sel_rst) begin
    if (sel_rst) begin
      out_idx_r <= 4'h0;
    end else begin
      out_idx_r <= bit_cnt_r[3:0];
    end
  end

  assign serial_out_o = frm.reply_word[4'hf - out_idx_r];
  assign serial_out_oe_o = !serial_select_n_i;
  assign frm.frame_word = frame_r;
  assign frm.frame_tgl = tgl_r;
endmodule // spi_link
`default_nettype wire

/* logic/star_config_top.sv */
// Configuration register of the star coupler, its feature gating and status latching.
// Assumes status and fault inputs on clk_i; raw line inputs arrive from pins.
// How it works
// - Host reads and writes config; fields steer branch, port and detection logic.
// - Bit 11: when set, tx fault in normal mode requests quiet mode.
// - Bit 10, reset 1: bus fault pulses shorter than timeout are filtered.
// - Bits 9..6, reset 1: per-branch wake receiver enables.
// - Bit 5, reset 0: when clear the receive-data driver is off.
// - Bit 4, reset 1: enables both star link interfaces together.
// - Bit 2, reset 1: enables stuck-line detection everywhere.
// - With detection on, any stuck flag raises the clamp error output.
// - Bit 1, reset 0: general and branch status bits hold latched values until read.
// - With latching on, reading a status register releases its latch.
// - With latching off, status reads show the live condition.
// - Bit 0 reads as odd parity over the returned word.
// - Frames are 16 bits; top three bits address; 111 selects config.
// - Frame bit 12 low writes bits 11..4, 2 and 1 (bits 3 and 0 stored as 0); high makes it read-only.
// - MSB-first full duplex; sample on falling, shift on rising edge.
`timescale 1ns/10ps
`default_nettype none
module star_config_top #(
  parameter int unsigned FILTER_CYCLES = star_cfg_pkg::FILTER_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  input wire logic serial_select_n_i,
  input wire logic serial_in_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  input wire logic [10:0] int_status_i,
  input wire logic [10:0] general_status_i,
  input wire logic [3:0][10:0] branch_status_i,
  input wire logic [3:0] branch_normal_i,
  input wire logic [3:0] branch_tx_fault_i,
  output logic [3:0] branch_quiet_req_o,
  input wire logic [3:0] bus_fault_raw_i,
  output logic [3:0] bus_fault_o,
  output logic glitch_filter_timer_en_o,
  input wire logic [3:0] branch_wake_raw_i,
  output logic [3:0] branch_wake_detect_en_o,
  output logic [3:0] branch_wake_event_o,
  input wire logic rx_data_i,
  output logic rx_data_o,
  output logic rx_data_oe_o,
  output logic star_link_en_o,
  input wire logic tx_gate_stuck_flag_i,
  input wire logic star_link_stuck_flag_i,
  input wire logic [3:0] branch_stuck_flag_i,
  output logic stuck_line_detect_en_o,
  output logic clamp_error_o
);
  localparam int unsigned CW = $clog2(FILTER_CYCLES + 1);
  localparam logic [CW-1:0] FILT_LAST = CW'(FILTER_CYCLES - 1);

  function automatic logic [11:0] with_parity(input logic [10:0] d);
    with_parity = {d, ~^d};
  endfunction

  spi_frame_if frm ();

  spi_link u_link (
    .rst_i(rst_i),
    .link_clk_i(link_clk_i),
    .serial_select_n_i(serial_select_n_i),
    .serial_in_i(serial_in_i),
    .serial_out_o(serial_out_o),
    .serial_out_oe_o(serial_out_oe_o),
    .frm(frm)
  );

  // Frame toggle crossing; the word itself is stable once the toggle is seen
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_s3_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end else begin
      tgl_s1_r <= frm.frame_tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  wire new_frame = tgl_s2_r ^ tgl_s3_r;
  wire [2:0] frame_addr = frm.frame_word[star_cfg_pkg::ADDR_MSB:star_cfg_pkg::ADDR_LSB];
  wire frame_wr = !frm.frame_word[star_cfg_pkg::RO_BIT];
  wire cfg_hit = new_frame && (frame_addr == star_cfg_pkg::ADDR_CONFIG);
  wire cfg_write = cfg_hit && frame_wr;

  // Configuration register
  logic [11:0] cfg_r;
  logic [11:0] cfg_nxt;
  assign cfg_nxt = frm.frame_word[11:0] & star_cfg_pkg::CFG_WR_MASK;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_r <= star_cfg_pkg::CFG_RESET;
    end else if (cfg_write) begin
      cfg_r <= cfg_nxt;
    end
  end

  wire aec_en = cfg_r[star_cfg_pkg::AEC_BIT];
  wire filt_en = cfg_r[star_cfg_pkg::FILT_BIT];
  wire [3:0] wake_en = cfg_r[star_cfg_pkg::WAKE_MSB:star_cfg_pkg::WAKE_LSB];
  wire port_en = cfg_r[star_cfg_pkg::PORT_BIT];
  wire stuck_en = cfg_r[star_cfg_pkg::STUCK_BIT];
  wire latch_en = cfg_r[star_cfg_pkg::LATCH_BIT];

  assign glitch_filter_timer_en_o = filt_en;
  assign branch_wake_detect_en_o = wake_en;
  assign star_link_en_o = cfg_r[star_cfg_pkg::LINK_BIT];
  assign stuck_line_detect_en_o = stuck_en;
  assign rx_data_oe_o = port_en;

  // Pin synchronisers for raw bus-fault and wake lines
  logic [3:0] fault_s1_r;
  logic [3:0] fault_s2_r;
  logic [3:0] wake_s1_r;
  logic [3:0] wake_s2_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_s1_r <= 4'h0;
      fault_s2_r <= 4'h0;
      wake_s1_r <= 4'h0;
      wake_s2_r <= 4'h0;
    end else begin
      fault_s1_r <= bus_fault_raw_i;
      fault_s2_r <= fault_s1_r;
      wake_s1_r <= branch_wake_raw_i;
      wake_s2_r <= wake_s1_r;
    end
  end

  // Feature outputs; receive data is zero while the port is off
  wire stuck_any = tx_gate_stuck_flag_i | star_link_stuck_flag_i | (|branch_stuck_flag_i);
  logic [3:0] quiet_r;
  logic [3:0] wake_evt_r;
  logic clamp_r;
  logic rx_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      quiet_r <= 4'h0;
      wake_evt_r <= 4'h0;
      clamp_r <= 1'b0;
      rx_r <= 1'b0;
    end else begin
      quiet_r <= {4{aec_en}} & branch_tx_fault_i & branch_normal_i;
      wake_evt_r <= wake_en & wake_s2_r;
      clamp_r <= stuck_en & stuck_any;
      rx_r <= port_en & rx_data_i;
    end
  end
  assign branch_quiet_req_o = quiet_r;
  assign branch_wake_event_o = wake_evt_r;
  assign clamp_error_o = clamp_r;
  assign rx_data_o = rx_r;

  // Glitch filter: a change passes only after it holds for FILTER_CYCLES
  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_filt
      logic [CW-1:0] cnt_r;
      logic filt_r;
      wire differs = fault_s2_r[b] != filt_r;
      wire expire = differs && (cnt_r == FILT_LAST);
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          cnt_r <= '0;
          filt_r <= 1'b0;
        end else if (!filt_en || expire) begin
          cnt_r <= '0;
          filt_r <= fault_s2_r[b];
        end else begin
          cnt_r <= differs ? cnt_r + CW'(1) : '0;
        end
      end
      assign bus_fault_o[b] = filt_r;
    end
  endgenerate

  // Status latching for the general and four branch status words
  logic [4:0][10:0] stat_live;
  logic [4:0][10:0] stat_shown;
  logic [4:0] stat_rd;
  assign stat_live = {branch_status_i, general_status_i};
  genvar s;
  generate
    for (s = 0; s < 5; s++) begin : g_stat
      logic [10:0] latch_r;
      logic [10:0] latch_nxt;
      assign stat_rd[s] = new_frame && (frame_addr == star_cfg_pkg::ADDR_GEN_STATUS + 3'(s));
      // A read reloads live bits, so an event in the read cycle is kept
      assign latch_nxt = (!latch_en || stat_rd[s]) ? stat_live[s] : (latch_r | stat_live[s]);
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          latch_r <= 11'h000;
        end else begin
          latch_r <= latch_nxt;
        end
      end
      assign stat_shown[s] = latch_en ? latch_r : stat_live[s];
    end
  endgenerate

  // Reply for the frame just seen; it is shifted out during the next frame
  logic [10:0] rd_bits;
  always_comb begin
    rd_bits = 11'h000;
    case (frame_addr)
      star_cfg_pkg::ADDR_CONTROL: rd_bits = 11'h000;
      star_cfg_pkg::ADDR_INT_STATUS: rd_bits = int_status_i;
      star_cfg_pkg::ADDR_CONFIG: rd_bits = cfg_r[11:1];
      default: rd_bits = stat_shown[frame_addr - star_cfg_pkg::ADDR_GEN_STATUS];
    endcase
  end

  logic [15:0] reply_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reply_r <= 16'h0000;
    end else if (new_frame) begin
      reply_r <= {4'h0, with_parity(rd_bits)};
    end
  end
  assign frm.reply_word = reply_r;

  // Checks
  a_aec_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (aec_en && branch_tx_fault_i[0] && branch_normal_i[0]) |=> branch_quiet_req_o[0])
    else $error("quiet request missing after tx fault");
  a_no_aec_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !aec_en ##1 !aec_en |-> !branch_quiet_req_o[1])
    else $error("quiet request with confinement off");
  a_wake_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    !wake_en[2] |=> !branch_wake_event_o[2])
    else $error("wake event on disabled branch");
  a_port_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !port_en ##1 !port_en |-> !rx_data_o && !rx_data_oe_o)
    else $error("receive driver active while port disabled");
  a_cfg_write: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_write |=> cfg_r == ($past(frm.frame_word[11:0]) & star_cfg_pkg::CFG_WR_MASK))
    else $error("config write not stored");
  a_cfg_readonly: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg_hit && !frame_wr) |=> $stable(cfg_r))
    else $error("read-only frame changed config");
  a_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_r[3] && !cfg_r[0])
    else $error("reserved or parity bit stored");
  a_parity_odd: assert property (@(posedge clk_i) disable iff (rst_i)
    new_frame |=> (^reply_r[11:0]) == 1'b1)
    else $error("reply word parity not odd");
  a_clamp_raise: assert property (@(posedge clk_i) disable iff (rst_i)
    (stuck_en && tx_gate_stuck_flag_i) |=> clamp_error_o)
    else $error("clamp error not raised");
  a_latch_release: assert property (@(posedge clk_i) disable iff (rst_i)
    (latch_en && stat_rd[0]) ##1 latch_en |-> stat_shown[0] == $past(stat_live[0]))
    else $error("latch not released by read");
  a_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (latch_en && !stat_rd[1]) ##1 latch_en
      |-> (stat_shown[1] & $past(stat_live[1])) == $past(stat_live[1]))
    else $error("latched status bit lost");
  a_live_read: assert property (@(posedge clk_i) disable iff (rst_i)
    (!latch_en && new_frame && frame_addr == star_cfg_pkg::ADDR_GEN_STATUS)
      |=> reply_r[11:1] == $past(general_status_i))
    else $error("live status not returned");
  a_filter_min: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(filt_en) && $changed(bus_fault_o[0]))
      |-> $past(fault_s2_r[0], 2) == bus_fault_o[0])
    else $error("single-cycle glitch passed filter");

  // Gating of branch features and receive data; each output lags its enable by one flop
  a_quiet_all_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !aec_en |=> branch_quiet_req_o == 4'h0)
    else $error("quiet request while confinement disabled");
  a_quiet_needs_normal: assert property (@(posedge clk_i) disable iff (rst_i)
    !branch_normal_i[2] |=> !branch_quiet_req_o[2])
    else $error("quiet request outside normal mode");
  a_quiet_branch3: assert property (@(posedge clk_i) disable iff (rst_i)
    (aec_en && branch_tx_fault_i[3] && branch_normal_i[3]) |=> branch_quiet_req_o[3])
    else $error("quiet request missing on branch 3");
  a_wake_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    (wake_en[0] && wake_s2_r[0]) |=> branch_wake_event_o[0])
    else $error("enabled wake event not flagged");
  a_wake_pass3: assert property (@(posedge clk_i) disable iff (rst_i)
    (wake_en[3] && wake_s2_r[3]) |=> branch_wake_event_o[3])
    else $error("enabled wake event missing on branch 3");
  a_wake_all_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (wake_en == 4'h0) |=> branch_wake_event_o == 4'h0)
    else $error("wake event with all detection disabled");
  a_rx_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    port_en |=> rx_data_o == $past(rx_data_i))
    else $error("receive data not passed while port enabled");

  // Register and reply checks
  a_cfg_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !cfg_write |=> $stable(cfg_r))
    else $error("config changed without a write frame");
  a_other_addr: assert property (@(posedge clk_i) disable iff (rst_i)
    (new_frame && frame_addr != star_cfg_pkg::ADDR_CONFIG) |=> $stable(cfg_r))
    else $error("frame to another address changed config");
  a_reply_stable: assert property (@(posedge clk_i) disable iff (rst_i)
    !new_frame |=> $stable(reply_r))
    else $error("reply word moved between frames");
  a_reply_top: assert property (@(posedge clk_i) disable iff (rst_i)
    new_frame |=> reply_r[15:12] == 4'h0)
    else $error("reply word upper bits not zero");

  // Detection and filtering; the filter must not move while input agrees
  a_clamp_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !stuck_en |=> !clamp_error_o)
    else $error("clamp error with detection disabled");
  a_clamp_none: assert property (@(posedge clk_i) disable iff (rst_i)
    !stuck_any |=> !clamp_error_o)
    else $error("clamp error without a stuck flag");
  a_clamp_branch: assert property (@(posedge clk_i) disable iff (rst_i)
    (stuck_en && branch_stuck_flag_i[3]) |=> clamp_error_o)
    else $error("branch clamp not raised");
  a_clamp_link: assert property (@(posedge clk_i) disable iff (rst_i)
    (stuck_en && star_link_stuck_flag_i) |=> clamp_error_o)
    else $error("star link clamp not raised");
  a_filt_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    !filt_en |=> bus_fault_o[1] == $past(fault_s2_r[1]))
    else $error("unfiltered bus fault not followed");
  a_filter_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (filt_en && (fault_s2_r[2] == bus_fault_o[2])) |=> $stable(bus_fault_o[2]))
    else $error("filtered bus fault moved without cause");

  c_cfg_write: cover property (@(posedge clk_i) disable iff (rst_i) cfg_write);
  c_filter_pass: cover property (@(posedge clk_i) disable iff (rst_i) $rose(bus_fault_o[0]));
  c_latch_read: cover property (@(posedge clk_i) disable iff (rst_i) latch_en && stat_rd[0]);
  c_clamp: cover property (@(posedge clk_i) disable iff (rst_i) $rose(clamp_error_o));
  c_quiet: cover property (@(posedge clk_i) disable iff (rst_i) |branch_quiet_req_o);
endmodule // star_config_top
`default_nettype wire

/* shared/spi_frame_if.sv */
// Carrier between the serial link logic and the register core.
// frame_word and reply_word are held stable between frames.
`timescale 1ns/10ps
`default_nettype none
interface spi_frame_if;
  logic [15:0] frame_word;
  logic frame_tgl;
  logic [15:0] reply_word;
  modport link (output frame_word, output frame_tgl, input reply_word);
  modport core (input frame_word, input frame_tgl, output reply_word);
endinterface
`default_nettype wire

/* shared/star_cfg_pkg.sv */
// Constants for the star coupler configuration register and its serial access.
// Assumes a 100 MHz core clock; the serial clock comes from the host.
package star_cfg_pkg;
  localparam int unsigned FRAME_W = 16;
  localparam int unsigned DATA_W = 12;
  localparam int unsigned STAT_W = 11;
  localparam int unsigned BRANCHES = 4;
  localparam int unsigned ADDR_MSB = 15;
  localparam int unsigned ADDR_LSB = 13;
  localparam int unsigned RO_BIT = 12;
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_INT_STATUS = 3'h1;
  localparam logic [2:0] ADDR_GEN_STATUS = 3'h2;
  localparam logic [2:0] ADDR_CONFIG = 3'h7;
  localparam int unsigned AEC_BIT = 11;
  localparam int unsigned FILT_BIT = 10;
  localparam int unsigned WAKE_MSB = 9;
  localparam int unsigned WAKE_LSB = 6;
  localparam int unsigned PORT_BIT = 5;
  localparam int unsigned LINK_BIT = 4;
  localparam int unsigned RSVD_BIT = 3;
  localparam int unsigned STUCK_BIT = 2;
  localparam int unsigned LATCH_BIT = 1;
  localparam int unsigned PARITY_BIT = 0;
  localparam logic [11:0] CFG_RESET = 12'h07d4;
  localparam logic [11:0] CFG_WR_MASK = 12'h0ff6;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FILTER_TIME_NS = 1000;
  localparam int unsigned FILTER_CYCLES =
    (FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* testbench/spi_host_model.sv */
// Host controller model on the far side of the serial link.
// Each transfer ends with its own gap; the link clock runs only inside frames.
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  output logic link_clk_o,
  output logic select_n_o,
  output logic data_o,
  input wire logic data_i
);
  initial begin
    link_clk_o = 1'b0;
    select_n_o = 1'b1;
    data_o = 1'b0;
  end

  // One full-duplex frame; the reply belongs to the previous frame's address
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    link_clk_o = 1'b0;
    select_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #62.5 link_clk_o = 1'b1;
      data_o = tx[i];
      #62.5 link_clk_o = 1'b0;
      rx[i] = data_i;
    end
    #62.5 select_n_o = 1'b1;
    // Released line: no pull, so show the inverse rather than a stale bit
    data_o = ~data_o;
    // Gap covers the select-high minimum and the core's sync latency
    #300;
  endtask
endmodule // spi_host_model
`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the star coupler configuration register.
// Assumes the host model drives the link; status and fault inputs on clk_i.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk_i, rst_i, link_clk, sel_n, ser_in, ser_out, ser_oe;
  logic [10:0] gen_stat;
  logic [3:0][10:0] br_stat;
  logic [3:0] normal, tx_fault, bus_raw, wake_raw, stuck_br;
  logic rx_in, gate_stuck, link_stuck;
  logic [3:0] quiet, bus_flt, wake_en, wake_ev;
  logic filt_en, rx_out, rx_oe, link_en, stuck_en, clamp_err;
  logic [15:0] rx;
  int error_cnt = 0;
  int tests_run = 0;

  star_config_top #(.FILTER_CYCLES(4)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk),
    .serial_select_n_i(sel_n), .serial_in_i(ser_in),
    .serial_out_o(ser_out), .serial_out_oe_o(ser_oe),
    .int_status_i('0), .general_status_i(gen_stat), .branch_status_i(br_stat),
    .branch_normal_i(normal), .branch_tx_fault_i(tx_fault),
    .branch_quiet_req_o(quiet), .bus_fault_raw_i(bus_raw), .bus_fault_o(bus_flt),
    .glitch_filter_timer_en_o(filt_en), .branch_wake_raw_i(wake_raw),
    .branch_wake_detect_en_o(wake_en), .branch_wake_event_o(wake_ev),
    .rx_data_i(rx_in), .rx_data_o(rx_out), .rx_data_oe_o(rx_oe),
    .star_link_en_o(link_en), .tx_gate_stuck_flag_i(gate_stuck),
    .star_link_stuck_flag_i(link_stuck), .branch_stuck_flag_i(stuck_br),
    .stuck_line_detect_en_o(stuck_en), .clamp_error_o(clamp_err)
  );

  spi_host_model host_u (
    .link_clk_o(link_clk), .select_n_o(sel_n), .data_o(ser_in), .data_i(ser_out)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Returned word: four zeros, bits 11..1, odd parity in bit 0
  function automatic logic [15:0] word(input logic [11:0] d);
    return {4'h0, d[11:1], ~^d[11:1]};
  endfunction

  // All activity inputs are held active, so each output mirrors its enable
  function automatic logic [17:0] outs_exp(input logic [11:0] c);
    return {{4{c[11]}}, c[9:6], c[2], c[5], c[5], c[4], c[2], c[10], c[9:6]};
  endfunction

  task chk(input logic [17:0] got, input logic [17:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task frame(input logic [15:0] tx);
    host_u.xfer(tx, rx);
  endtask

  // Reads are pipelined one frame, so a dummy config read fetches the answer
  task rd(input logic [2:0] addr, input logic [15:0] exp);
    frame({addr, 1'b1, 12'h000});
    frame({3'h7, 1'b1, 12'h000});
    chk({2'b00, rx}, {2'b00, exp}, "read");
  endtask

  task outs(input logic [11:0] c);
    repeat (4) @(posedge clk_i);
    #1;
    chk({quiet, wake_ev, clamp_err, rx_out, rx_oe, link_en, stuck_en, filt_en, wake_en},
      outs_exp(c), "outputs");
    chk({17'h0_0000, ser_oe}, 18'h0_0000, "select idle");
  endtask

  task step(input logic [11:0] c);
    frame({3'h7, 1'b0, c});
    rd(3'h7, word(c & 12'hff6));
    outs(c);
  endtask

  task glitch(input int len, input logic [3:0] exp);
    logic [3:0] seen;
    seen = 4'h0;
    @(posedge clk_i);
    bus_raw <= 4'hf;
    for (int i = 0; i < len + 12; i++) begin
      @(posedge clk_i);
      if (i == len - 1) bus_raw <= 4'h0;
      #1 seen = seen | bus_flt;
    end
    chk({14'h0000, seen}, {14'h0000, exp}, "filter");
  endtask

  task stat(input logic [10:0] p, input logic [10:0] s);
    @(posedge clk_i);
    gen_stat <= p;
    br_stat[0] <= p;
    repeat (3) @(posedge clk_i);
    gen_stat <= s;
    br_stat[0] <= s;
    repeat (3) @(posedge clk_i);
  endtask

  task report_and_stop();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #500000;
    error_cnt++;
    $display("wrong value at %0t: run timed out", $time);
    report_and_stop();
  end

  initial begin
    rst_i = 1'b1;
    gen_stat = 11'h000;
    br_stat = '0;
    normal = 4'hf;
    tx_fault = 4'hf;
    bus_raw = 4'h0;
    wake_raw = 4'hf;
    stuck_br = 4'hf;
    rx_in = 1'b1;
    gate_stuck = 1'b1;
    link_stuck = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    frame({3'h7, 1'b1, 12'h000});
    chk({2'b00, rx}, 18'h0_0000, "first reply");
    rd(3'h7, word(12'h7d4));
    outs(12'h7d4);
    // Complementary patterns toggle every field on and off; only bit 11 is ever set on its own
    step(12'h000);
    step(12'hfff);
    step(12'h800);
    step(12'h555);
    step(12'haaa);
    step(12'h7d4);
    frame({3'h7, 1'b1, 12'h000});
    rd(3'h7, word(12'h7d4));
    frame({3'h2, 1'b0, 12'h000});
    rd(3'h7, word(12'h7d4));
    glitch(3, 4'h0);
    glitch(20, 4'hf);
    frame({3'h7, 1'b0, 12'h3d4});
    glitch(3, 4'hf);
    frame({3'h7, 1'b0, 12'h7d6});
    stat(11'h001, 11'h400);
    rd(3'h2, word({11'h401, 1'b0}));
    rd(3'h2, word({11'h400, 1'b0}));
    rd(3'h3, word({11'h401, 1'b0}));
    frame({3'h7, 1'b0, 12'h7d4});
    stat(11'h001, 11'h400);
    rd(3'h2, word({11'h400, 1'b0}));
    rd(3'h3, word({11'h400, 1'b0}));
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
